// *** design/belt_pkg.sv ***
// ----------------------------------------------------------------------------
// belt_pkg: constants, register map and types of the belt speed trip monitor
// ----------------------------------------------------------------------------
// assumes one 25 MHz clock; all slow timing counts in ticks of TICK_MS
package belt_pkg;

   // clock and slow tick
   localparam int CLK_HZ      = 25_000_000;
   localparam int TICK_MS     = 100;
   localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;

   // times in ms and their tick counts
   localparam int HOLD_MS     = 4000;
   localparam int UNDER_MS    = 1500;
   localparam int OVER_A_MS   = 2000;
   localparam int OVER_S_MS   = 20000;
   localparam int MIS_LAMP_MS = 2000;
   localparam int MIS_RLY_MS  = 13000;
   localparam int HOT_MS      = 1500;
   localparam int ACC_MS      = 180000;
   localparam int CAL_MS      = 16000;
   localparam int ACCEL_MS    = 2000;
   localparam int WIN_MS      = 1000;
   localparam int HOLD_TK     = HOLD_MS / TICK_MS;
   localparam int UNDER_TK    = UNDER_MS / TICK_MS;
   localparam int OVER_A_TK   = OVER_A_MS / TICK_MS;
   localparam int OVER_S_TK   = OVER_S_MS / TICK_MS;
   localparam int MIS_LAMP_TK = MIS_LAMP_MS / TICK_MS;
   localparam int MIS_RLY_TK  = MIS_LAMP_TK + MIS_RLY_MS / TICK_MS;
   localparam int HOT_TK      = HOT_MS / TICK_MS;
   localparam int ACC_TK      = ACC_MS / TICK_MS;
   localparam int CAL_TK      = CAL_MS / TICK_MS;
   localparam int ACCEL_TK    = ACCEL_MS / TICK_MS;
   localparam int WIN_TK      = WIN_MS / TICK_MS;

   // register byte offsets
   localparam logic [7:0] OFS_CAL  = 8'h00;
   localparam logic [7:0] OFS_TRIP = 8'h04;
   localparam logic [7:0] OFS_SUP  = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_SPD  = 8'h10;
   localparam logic [7:0] OFS_ACC  = 8'h14;

   // reset values
   localparam logic [15:0] CAL_RST = 16'h0064;
   localparam logic [7:0]  APCT_RST = 8'h0F;
   localparam logic [7:0]  SPCT_RST = 8'h14;
   localparam logic [11:0] SUP_RST  = 12'h064;

   // ramp step divisor shift and overshoot margin in steps
   localparam int STEP_SH = 5;
   localparam int OVR_STEPS = 4;

   // front-panel lamps
   typedef struct packed {
      logic probe1;
      logic probe2;
      logic under;
      logic over;
      logic misalign;
      logic hot;
      logic alarm;
      logic stop;
   } lamps_t;

   typedef enum logic [3:0] {
      T_IDLE, T_SHOW, T_UP_OA, T_HOLD_OA, T_UP_OS, T_HOLD_OS, T_UP_OVR,
      T_DN_UA, T_HOLD_UA, T_DN_US, T_HOLD_US, T_DN_UND, T_UP_CAL
   } sweep_t;

endpackage

// *** design/belt_speed_trip_monitor.sv ***
// ----------------------------------------------------------------------------
// belt_speed_trip_monitor: speed supervision, test sweep and relay control
// ----------------------------------------------------------------------------
// assumes an APB master on sys_clk; probe, key and sensor pins synchronous
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// Summary of operation
// - test starts showing calibrated speed four seconds
// - ramp to overspeed alarm, hold, lamps only
// - ramp to overspeed stop, hold, add stop lamp
// - overshoot then ramp down, clearing lamps
// - down to underspeed alarm, hold, lamps only
// - down to underspeed stop, hold, stop lamp
// - undershoot then ramp up, clearing lamps
// - sweep ends at calibrated speed, show speed
// - relays act during test, lamps deferred
// - interlock starts startup timer before comparing
// - probe lamp toggles per processed pulse
// - average each probe, display the higher
// - underspeed alarm lamps now, relay after 1.5s
// - underspeed stop after 1.5s, latched till restart
// - startup suppresses underspeed, checks acceleration
// - overspeed alarm relay drops after 2s
// - overspeed stop after 20s, latched
// - misalignment lamps at 2s, relay 13s later
// - hot bearing lamps now, relay 1.5s later
// - accumulated alarm over three minutes stops
// - accumulator counts up and down, floor zero
// - motor restart clears accumulated alarm time
// - calibration averages both probes sixteen seconds
module belt_speed_trip_monitor import belt_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int WIN_TICKS   = WIN_TK,
   parameter int N_HOT       = 4
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // field inputs
   input  wire logic             probe1,
   input  wire logic             probe2,
   input  wire logic [N_HOT-1:0] hot_bearing,
   input  wire logic             motor_run,
   input  wire logic             test_key,
   input  wire logic             cal_key,
   // lamps, relays, display
   output lamps_t                lamps,
   output logic                  alarm_relay,
   output logic                  stop_relay,
   output logic [15:0]           disp_speed
);
   typedef struct packed {
      logic [31:0] div;
      logic        tick;
      logic        run_prev;
      logic        tkey_prev;
      logic        ckey_prev;
      sweep_t      tst;
      logic [7:0]  ttim;
      logic [15:0] tval;
      logic [11:0] sup;
      logic        started;
      logic [7:0]  t_ua;
      logic [7:0]  t_us;
      logic [7:0]  t_oa;
      logic [7:0]  t_os;
      logic [7:0]  t_mis;
      logic [7:0]  t_hot;
      logic [10:0] acc;
      logic        stop_lat;
      lamps_t      lat;
      logic [15:0] cal;
      logic [7:0]  a_pct;
      logic [7:0]  s_pct;
      logic [11:0] sup_tk;
      logic        cal_busy;
      logic [7:0]  cal_tim;
      logic [24:0] cal_sum;
      logic [31:0] rdata;
      lamps_t      lamps;
      logic        alarm_rly;
      logic        stop_rly;
      logic [15:0] disp;
   } st_t;

   st_t q, d;
   logic [1:0]  rs_q;
   logic        rst_n;
   logic [15:0] rate1, rate2;
   logic        plamp1, plamp2;

   // ------------------------------------------------------------------------
   // reset release and probe rate meters
   // ------------------------------------------------------------------------
   // reset deasserts through two flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) rs_q <= 2'b00;
      else          rs_q <= {rs_q[0], 1'b1};
   end
   assign rst_n = rs_q[1];

   rate_meter #(.WIN_TICKS(WIN_TICKS), .W(16)) u_rm1 (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .tick  (q.tick),
      .pulse (probe1),
      .rate  (rate1),
      .lamp  (plamp1)
   );

   rate_meter #(.WIN_TICKS(WIN_TICKS), .W(16)) u_rm2 (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .tick  (q.tick),
      .pulse (probe2),
      .rate  (rate2),
      .lamp  (plamp2)
   );

   // ------------------------------------------------------------------------
   // thresholds and live conditions
   // ------------------------------------------------------------------------
   logic [15:0] spd, da, ds, ua, us, oa, os, step;
   logic [23:0] pa, ps;
   logic        running, armed;
   logic        c_ua, c_us, c_oa, c_os, c_mis, c_hot;

   // trip points from calibrated speed and percentages
   always_comb begin
      spd  = (rate1 > rate2) ? rate1 : rate2;
      pa   = q.cal * q.a_pct;
      ps   = q.cal * q.s_pct;
      da   = 16'(pa / 24'd100);
      ds   = 16'(ps / 24'd100);
      ua   = q.cal - da;
      us   = q.cal - ds;
      oa   = q.cal + da;
      os   = q.cal + ds;
      step = ((q.cal >> STEP_SH) == 16'h0000) ? 16'h0001 : (q.cal >> STEP_SH);
   end

   // speed compares only after startup delay
   always_comb begin
      running = motor_run;
      armed   = running & q.started;
      c_ua    = armed & (spd < ua);
      c_us    = armed & (spd < us);
      c_oa    = armed & (spd > oa);
      c_os    = armed & (spd > os);
      c_mis   = armed & ((({2'b00, rate1} * 18'd3) < ({2'b00, rate2} * 18'd2)) |
                         (({2'b00, rate2} * 18'd3) < ({2'b00, rate1} * 18'd2)));
      c_hot   = |hot_bearing;
   end

   // ------------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------------
   always_comb begin
      lamps_t real_l, test_l;
      logic   alarm_off, stop_trip, accel_bad, restart;
      logic   wr, rd_setup;
      d         = q;
      real_l    = '0;
      test_l    = '0;
      wr        = psel & penable & pwrite;
      rd_setup  = psel & ~penable;
      restart   = motor_run & ~q.run_prev;

      // slow tick divider
      d.tick = 1'b0;
      if (q.div == 32'(TICK_CYCLES - 1)) begin
         d.div  = '0;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 32'd1;
      end
      d.run_prev  = motor_run;
      d.tkey_prev = test_key;
      d.ckey_prev = cal_key;

      // startup timer
      if (!running) begin
         d.sup     = '0;
         d.started = 1'b0;
      end else if (q.tick && !q.started) begin
         if (q.sup >= q.sup_tk) d.started = 1'b1;
         else                   d.sup = q.sup + 12'd1;
      end
      accel_bad = running & ~q.started &
                  (q.sup >= 12'(ACCEL_TK)) & (spd == 16'h0000);

      // persistence timers, cleared when condition goes
      if (q.tick) begin
         if (q.t_ua  != 8'hFF) d.t_ua  = q.t_ua + 8'd1;
         if (q.t_us  != 8'hFF) d.t_us  = q.t_us + 8'd1;
         if (q.t_oa  != 8'hFF) d.t_oa  = q.t_oa + 8'd1;
         if (q.t_os  != 8'hFF) d.t_os  = q.t_os + 8'd1;
         if (q.t_mis != 8'hFF) d.t_mis = q.t_mis + 8'd1;
         if (q.t_hot != 8'hFF) d.t_hot = q.t_hot + 8'd1;
      end
      if (!c_ua)  d.t_ua  = '0;
      if (!c_us)  d.t_us  = '0;
      if (!c_oa)  d.t_oa  = '0;
      if (!c_os)  d.t_os  = '0;
      if (!c_mis) d.t_mis = '0;
      if (!c_hot) d.t_hot = '0;

      // live lamp picture
      real_l.probe1   = plamp1;
      real_l.probe2   = plamp2;
      real_l.under    = c_ua;
      real_l.over     = c_oa;
      real_l.misalign = q.t_mis >= 8'(MIS_LAMP_TK);
      real_l.hot      = c_hot;
      real_l.alarm    = real_l.under | real_l.over | real_l.misalign | real_l.hot;
      real_l.stop     = c_us | c_os;

      // alarm relay drop conditions
      alarm_off = (q.t_ua >= 8'(UNDER_TK)) |
                  (q.t_oa >= 8'(OVER_A_TK)) |
                  (q.t_mis >= 8'(MIS_RLY_TK)) |
                  (q.t_hot >= 8'(HOT_TK));

      // accumulated alarm time up and down
      if (q.tick) begin
         if (real_l.alarm) begin
            if (q.acc != 11'h7FF) d.acc = q.acc + 11'd1;
         end else if (q.acc != 11'h000) begin
            d.acc = q.acc - 11'd1;
         end
      end

      // stop trip and latch
      stop_trip = (q.t_us >= 8'(UNDER_TK)) |
                  (q.t_os >= 8'(OVER_S_TK)) |
                  (q.acc > 11'(ACC_TK)) |
                  accel_bad;
      if (stop_trip) begin
         d.stop_lat    = 1'b1;
         d.lat         = q.lat | real_l;
         d.lat.stop    = 1'b1;
         d.lat.probe1  = 1'b0;
         d.lat.probe2  = 1'b0;
         if (accel_bad) d.lat.under = 1'b1;
      end
      if (restart) begin
         d.stop_lat = 1'b0;
         d.lat      = '0;
         d.acc      = '0;
      end

      // relays energised while healthy, act even during test
      d.alarm_rly = ~(alarm_off | q.stop_lat);
      d.stop_rly  = ~q.stop_lat;

      // test sweep sequencer
      if (test_key && !q.tkey_prev && q.tst == T_IDLE) begin
         d.tst  = T_SHOW;
         d.tval = q.cal;
         d.ttim = '0;
      end else if (q.tick) begin
         unique case (q.tst)
            T_IDLE: begin
            end
            T_SHOW, T_HOLD_OA, T_HOLD_OS, T_HOLD_UA, T_HOLD_US: begin
               if (q.ttim == 8'(HOLD_TK - 1)) begin
                  d.ttim = '0;
                  unique case (q.tst)
                     T_SHOW:    d.tst = T_UP_OA;
                     T_HOLD_OA: d.tst = T_UP_OS;
                     T_HOLD_OS: d.tst = T_UP_OVR;
                     T_HOLD_UA: d.tst = T_DN_US;
                     default:   d.tst = T_DN_UND;
                  endcase
               end else begin
                  d.ttim = q.ttim + 8'd1;
               end
            end
            T_UP_OA: begin
               if (q.tval + step >= oa) begin
                  d.tval = oa;
                  d.tst  = T_HOLD_OA;
               end else d.tval = q.tval + step;
            end
            T_UP_OS: begin
               if (q.tval + step >= os) begin
                  d.tval = os;
                  d.tst  = T_HOLD_OS;
               end else d.tval = q.tval + step;
            end
            T_UP_OVR: begin
               d.tval = q.tval + step;
               if (q.tval >= os + 16'(OVR_STEPS) * step) d.tst = T_DN_UA;
            end
            T_DN_UA: begin
               if (q.tval <= ua + step) begin
                  d.tval = ua;
                  d.tst  = T_HOLD_UA;
               end else d.tval = q.tval - step;
            end
            T_DN_US: begin
               if (q.tval <= us + step) begin
                  d.tval = us;
                  d.tst  = T_HOLD_US;
               end else d.tval = q.tval - step;
            end
            T_DN_UND: begin
               if (q.tval <= step || q.tval + 16'(OVR_STEPS) * step <= us)
                  d.tst = T_UP_CAL;
               else d.tval = q.tval - step;
            end
            T_UP_CAL: begin
               if (q.tval + step >= q.cal) begin
                  d.tval = q.cal;
                  d.tst  = T_IDLE;
               end else d.tval = q.tval + step;
            end
         endcase
      end

      // test lamps follow the swept value
      test_l.probe1 = plamp1;
      test_l.probe2 = plamp2;
      test_l.over   = q.tval >= oa;
      test_l.under  = q.tval <= ua;
      test_l.alarm  = test_l.over | test_l.under;
      test_l.stop   = (q.tval >= os) | (q.tval <= us);

      // lamp and display outputs
      if (q.tst != T_IDLE) begin
         d.lamps = test_l;
         d.disp  = q.tval;
      end else begin
         d.lamps = real_l | q.lat;
         d.disp  = spd;
      end

      // calibration run
      if (cal_key && !q.ckey_prev && !q.cal_busy) begin
         d.cal_busy = 1'b1;
         d.cal_tim  = '0;
         d.cal_sum  = '0;
      end else if (q.cal_busy && q.tick) begin
         d.cal_sum = q.cal_sum + 25'(rate1) + 25'(rate2);
         d.cal_tim = q.cal_tim + 8'd1;
         if (q.cal_tim == 8'(CAL_TK - 1)) begin
            d.cal_busy = 1'b0;
            d.cal      = 16'(d.cal_sum / 25'(2 * CAL_TK));
         end
      end

      // apb writes
      if (wr) begin
         unique case (paddr)
            OFS_CAL:  d.cal = pwdata[15:0];
            OFS_TRIP: begin
               d.a_pct = pwdata[7:0];
               d.s_pct = pwdata[15:8];
            end
            OFS_SUP:  d.sup_tk = pwdata[11:0];
            default: begin
            end
         endcase
      end

      // apb read data captured in setup phase
      if (rd_setup) begin
         unique case (paddr)
            OFS_CAL:  d.rdata = {16'h0000, q.cal};
            OFS_TRIP: d.rdata = {16'h0000, q.s_pct, q.a_pct};
            OFS_SUP:  d.rdata = {20'h00000, q.sup_tk};
            OFS_STAT: d.rdata = {16'h0000, 2'b00, q.cal_busy, q.tst != T_IDLE,
                                 q.started, q.stop_lat, q.stop_rly, q.alarm_rly,
                                 q.lamps};
            OFS_SPD:  d.rdata = {q.disp, spd};
            OFS_ACC:  d.rdata = {21'h000000, q.acc};
            default:  d.rdata = 32'h00000000;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q           <= '0;
         q.tst       <= T_IDLE;
         q.cal       <= CAL_RST;
         q.a_pct     <= APCT_RST;
         q.s_pct     <= SPCT_RST;
         q.sup_tk    <= SUP_RST;
         q.alarm_rly <= 1'b1;
         q.stop_rly  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // bus handshake and outputs
   assign pready      = 1'b1;
   assign pslverr     = psel & penable &
                        ~((paddr == OFS_CAL) | (paddr == OFS_TRIP) | (paddr == OFS_SUP) |
                          (paddr == OFS_STAT) | (paddr == OFS_SPD) | (paddr == OFS_ACC));
   assign prdata      = q.rdata;
   assign lamps       = q.lamps;
   assign alarm_relay = q.alarm_rly;
   assign stop_relay  = q.stop_rly;
   assign disp_speed  = q.disp;
endmodule

// *** design/rate_meter.sv ***
// ----------------------------------------------------------------------------
// rate_meter: counts probe pulses per window and averages the counts
// ----------------------------------------------------------------------------
// assumes pulse is synchronous to clk and tick is a one-cycle enable
`timescale 1ns/1ps
module rate_meter import belt_pkg::*; #(
   parameter int WIN_TICKS = WIN_TK,
   parameter int W         = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // timing and probe
   input  wire logic         tick,
   input  wire logic         pulse,
   // averaged rate and indicator
   output logic [W-1:0]      rate,
   output logic              lamp
);
   typedef struct packed {
      logic         prev;
      logic         lamp;
      logic [W-1:0] cnt;
      logic [7:0]   win;
      logic [W-1:0] avg;
   } rm_t;

   rm_t q, d;

   // edge count, window close, quarter-weight running average
   always_comb begin
      logic              edge_seen;
      logic signed [W:0] df;
      edge_seen = pulse & ~q.prev;
      df        = signed'({1'b0, q.cnt}) - signed'({1'b0, q.avg});
      d         = q;
      d.prev    = pulse;
      if (edge_seen) begin
         d.lamp = ~q.lamp;
         if (~&q.cnt) d.cnt = q.cnt + 1'b1;
      end
      if (tick) begin
         if (q.win == 8'(WIN_TICKS - 1)) begin
            d.win = 8'h00;
            d.cnt = {{(W-1){1'b0}}, edge_seen};
            d.avg = W'($unsigned(signed'({1'b0, q.avg}) + (df >>> 2)));
         end else begin
            d.win = q.win + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) q <= '0;
      else        q <= d;
   end

   assign rate = q.avg;
   assign lamp = q.lamp;
endmodule

// *** sim/belt_speed_trip_monitor_properties.sv ***
// checker: timing relations on the monitor's top-level ports
// assumes it is bound into every belt_speed_trip_monitor
`timescale 1ns/1ps
module belt_checks import belt_pkg::*; #(
   parameter int TICK_CYCLES = 10,
   parameter int N_HOT       = 4
) (
   // clock and reset
   input wire logic             sys_clk,
   input wire logic             reset_n,
   // apb
   input wire logic             psel,
   input wire logic             penable,
   input wire logic [7:0]       paddr,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   // field side
   input wire logic             probe1,
   input wire logic [N_HOT-1:0] hot_bearing,
   input wire logic             motor_run,
   input wire lamps_t           lamps,
   input wire logic             alarm_relay,
   input wire logic             stop_relay
);
   int   hot_q;
   logic mapped;
   // address hits one of the six words
   assign mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'b00);
   // clocks of unbroken over-temperature
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         hot_q <= 0;
      else
         hot_q <= (hot_bearing == '0) ? 0 : hot_q + 1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_pready_high: assert property (pready)
      else $error("pready low");
   a_bad_addr: assert property (psel && penable && !mapped |-> pslverr)
      else $error("unmapped access without error");
   a_good_addr: assert property (psel && penable && mapped |-> !pslverr)
      else $error("mapped access flagged");
   a_err_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("error outside access phase");
   a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
   a_stop_latched: assert property (!stop_relay && !(motor_run && !$past(motor_run, 4)) |=> !stop_relay)
      else $error("stop relay released without restart");
   a_stop_alarm: assert property ($fell(stop_relay) |-> ##[0:2] !alarm_relay)
      else $error("alarm relay held during stop");
   a_probe_quiet: assert property (!probe1 [*8] |=> $stable(lamps.probe1))
      else $error("probe lamp toggled without pulse");
   a_hot_relay: assert property (hot_q > 17 * TICK_CYCLES |-> !alarm_relay)
      else $error("alarm relay held on hot bearing");
endmodule

bind belt_speed_trip_monitor belt_checks #(.TICK_CYCLES(TICK_CYCLES), .N_HOT(N_HOT)) chk_i (
   .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .probe1(probe1), .hot_bearing(hot_bearing),
   .motor_run(motor_run), .lamps(lamps), .alarm_relay(alarm_relay), .stop_relay(stop_relay));

// *** sim/belt_speed_trip_monitor_tb.sv ***
// bench: apb tasks and field stimulus around the belt monitor
// assumes the checker is bound in and a 10-clock slow tick
`timescale 1ns/1ps
module belt_speed_trip_monitor_tb import belt_pkg::*;;
   localparam int TK = 10;
   logic        sys_clk, reset_n, psel, penable, pwrite, motor_run, test_key, cal_key;
   logic        pready, pslverr, alarm_relay, stop_relay, probe1, probe2, err;
   logic [7:0]  paddr, per1, per2;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  hot_bearing;
   logic [15:0] disp_speed;
   lamps_t      lamps;
   wire  [9:0]  obs = {stop_relay, alarm_relay, lamps};
   int          fails = 0;
   int          n_checks = 0;
   belt_speed_trip_monitor #(.TICK_CYCLES(TK), .WIN_TICKS(10)) dut (.*);
   probe_source src (.clk(sys_clk), .per1(per1), .per2(per2), .p1(probe1), .p2(probe2));
   // report counts and verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, result in rd and err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         fails++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic tk(input int n);
      repeat (n * TK) @(posedge sys_clk);
   endtask
   // bounded wait for one output bit
   task automatic waitb(input int idx, input logic v, input int n);
      int i;
      for (i = 0; i < n * TK && obs[idx] !== v; i++)
         @(posedge sys_clk);
      if (i >= n * TK) begin
         fails++;
         finish_test();
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // main sequence
   initial begin
      {reset_n, psel, penable, pwrite, motor_run, test_key, cal_key} = '0;
      {paddr, pwdata, hot_bearing, per1, per2} = '0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      apb(0, OFS_CAL, 0);
      chk(rd, {16'h0, CAL_RST});
      apb(0, OFS_TRIP, 0);
      chk(rd, {16'h0, SPCT_RST, APCT_RST});
      apb(0, OFS_SUP, 0);
      chk(rd, {20'h0, SUP_RST});
      apb(0, 8'h18, 0);
      chk({rd[30:0], err}, 32'h1);
      apb(1, OFS_CAL, 32'h14);
      apb(1, OFS_SUP, 32'h3C);
      apb(0, OFS_CAL, 0);
      chk(rd, 32'h14);
      {per1, per2, motor_run} <= {8'h4, 8'h5, 1'b1};
      tk(120);
      apb(0, OFS_SPD, 0);
      chk(rd, 32'h0016_0016);
      chk({24'h0, obs[9:8], obs[5:0]}, 32'hC0);
      $display("test normal run done");
      test_key <= 1'b1;
      tk(1);
      test_key <= 1'b0;
      tk(10);
      chk({16'h0, disp_speed}, 32'h14);
      waitb(4, 1, 200);
      tk(1);
      chk({11'h0, disp_speed, obs[9:8], obs[4], obs[1], obs[0]}, 32'h2FE);
      waitb(0, 1, 100);
      tk(1);
      chk({11'h0, disp_speed, obs[9:8], obs[4], obs[1], obs[0]}, 32'h31F);
      waitb(0, 0, 100);
      chk({31'h0, obs[4]}, 32'h1);
      waitb(4, 0, 50);
      waitb(5, 1, 100);
      tk(1);
      chk({11'h0, disp_speed, obs[9:8], obs[5], obs[1], obs[0]}, 32'h23E);
      waitb(0, 1, 100);
      tk(1);
      chk({11'h0, disp_speed, obs[9:8], obs[5], obs[1], obs[0]}, 32'h21F);
      waitb(0, 0, 100);
      waitb(5, 0, 50);
      tk(10);
      apb(0, OFS_STAT, 0);
      chk({15'h0, rd[12], disp_speed}, 32'h16);
      $display("test sweep done");
      hot_bearing <= 4'b0100;
      tk(1);
      chk({29'h0, obs[8], obs[2], obs[1]}, 32'h7);
      tk(16);
      chk({31'h0, obs[8]}, 32'h0);
      hot_bearing <= 4'b0000;
      tk(1);
      chk({30'h0, obs[8], obs[2]}, 32'h2);
      apb(0, OFS_ACC, 0);
      chk({31'h0, rd != 0}, 32'h1);
      tk(40);
      apb(0, OFS_ACC, 0);
      chk(rd, 32'h0);
      $display("test hot bearing done");
      per2 <= 8'h0;
      tk(5);
      chk({31'h0, obs[3]}, 32'h0);
      waitb(3, 1, 80);
      chk({30'h0, obs[8], obs[1]}, 32'h3);
      waitb(8, 0, 200);
      per2 <= 8'h5;
      tk(100);
      $display("test misalignment done");
      {per1, per2} <= {8'hA, 8'hA};
      waitb(5, 1, 100);
      chk({31'h0, obs[1]}, 32'h1);
      waitb(9, 0, 100);
      {per1, per2} <= {8'h4, 8'h5};
      tk(100);
      chk({27'h0, obs[9:8], obs[5], obs[1], obs[0]}, 32'h7);
      motor_run <= 1'b0;
      tk(2);
      motor_run <= 1'b1;
      tk(1);
      chk({27'h0, obs[9:8], obs[5], obs[1], obs[0]}, 32'h18);
      apb(0, OFS_ACC, 0);
      chk(rd, 32'h0);
      $display("test underspeed done");
      cal_key <= 1'b1;
      tk(1);
      cal_key <= 1'b0;
      tk(165);
      apb(0, OFS_CAL, 0);
      chk(rd, 32'h13);
      chk({29'h0, obs[8], obs[4], obs[1]}, 32'h7);
      waitb(8, 0, 30);
      $display("test calibration done");
      {per1, per2, motor_run} <= 17'h0;
      tk(120);
      motor_run <= 1'b1;
      waitb(9, 0, 40);
      chk({30'h0, obs[5], obs[0]}, 32'h3);
      $display("test acceleration done");
      finish_test();
   end
endmodule

// *** sim/probe_source.sv ***
// model of the two motion probes: one-clock pulses at set periods
// assumes the bench drives the periods in clocks, 0 holds a probe still
`timescale 1ns/1ps
module probe_source (
   // clock
   input  wire logic       clk,
   // pulse periods
   input  wire logic [7:0] per1,
   input  wire logic [7:0] per2,
   // probe pulses
   output logic            p1,
   output logic            p2
);
   logic [7:0] c1_q = '0;
   logic [7:0] c2_q = '0;
   // wrap counters, one pulse per wrap
   always_ff @(posedge clk) begin
      c1_q <= (c1_q + 8'h01 >= per1) ? '0 : c1_q + 8'h01;
      c2_q <= (c2_q + 8'h01 >= per2) ? '0 : c2_q + 8'h01;
      p1   <= (per1 != '0) && (c1_q == '0);
      p2   <= (per2 != '0) && (c2_q == '0);
   end
endmodule
